// ==== design/simd_alu_pkg.sv ====
// Shared encodings, field positions and reset values for the SIMD compare and complex unit
package simd_alu_pkg;

	// Instruction field positions
	localparam int OPC_LSB = 0;
	localparam int OPC_MSB = 6;
	localparam int DEST_LSB = 7;
	localparam int DEST_MSB = 11;
	localparam int SUB_LSB = 12;
	localparam int SUB_MSB = 14;
	localparam int SRC1_LSB = 15;
	localparam int SRC1_MSB = 19;
	localparam int SRC2_LSB = 20;
	localparam int SRC2_MSB = 24;
	localparam int IMM_LOW_BIT = 25;
	localparam int GROUP_BIT = 26;
	localparam int FUNC_LSB = 27;
	localparam int FUNC_MSB = 31;

	// Opcode and function codes
	localparam logic [6:0] OPC_CUSTOM = 7'h7b;
	localparam logic [4:0] FUNC_CMP_LAST = 5'h09;
	localparam logic [4:0] FUNC_CPLX_MUL = 5'h0a;
	localparam logic [4:0] FUNC_CPLX_CONJ = 5'h0b;
	localparam logic [4:0] FUNC_CPLX_SUBROT = 5'h0d;

	// Compare sub-function codes: bit 0 picks byte lanes, bits 2:1 the operand form
	localparam logic [1:0] FORM_VECTOR = 2'h0;
	localparam logic [1:0] FORM_SCALAR = 2'h2;
	localparam logic [1:0] FORM_IMM = 2'h3;

	// Complex multiply shift for the plain variant
	localparam logic [5:0] MUL_BASE_SHIFT = 6'h0f;

	// Values after reset
	localparam logic [31:0] DATA_RST = 32'h0000_0000;
	localparam logic [4:0] DEST_RST = 5'h00;

	typedef enum logic [3:0] {
		KIND_EQ = 4'b0000,
		KIND_NE = 4'b0001,
		KIND_GT = 4'b0010,
		KIND_GE = 4'b0011,
		KIND_LT = 4'b0100,
		KIND_LE = 4'b0101,
		KIND_GTU = 4'b0110,
		KIND_GEU = 4'b0111,
		KIND_LTU = 4'b1000,
		KIND_LEU = 4'b1001
	} cmp_kind_t;

endpackage

// ==== design/lane_compare_unit.sv ====
// Lane-wise compare producing an all-ones or all-zeros mask per lane
`timescale 1ns/10ps
module lane_compare_unit (
	input wire logic [31:0] lhs,
	input wire logic [31:0] rhs,
	input wire simd_alu_pkg::cmp_kind_t kind,
	input wire logic byte_lanes,
	output logic [31:0] mask
);
	import simd_alu_pkg::*;

	function automatic logic is_signed_kind(input cmp_kind_t k);
		begin
			is_signed_kind = (k == KIND_GT) || (k == KIND_GE) || (k == KIND_LT) || (k == KIND_LE);
		end
	endfunction

	// Byte lanes are widened so one 16-bit comparator serves both widths
	function automatic logic [15:0] widen(input logic [7:0] v, input logic sgn);
		begin
			widen = {{8{sgn & v[7]}}, v};
		end
	endfunction

	function automatic logic lane_hit(input logic [15:0] a, input logic [15:0] b,
		input cmp_kind_t k);
		logic eq;
		logic sgt;
		logic ugt;
		begin
			eq = (a == b);
			sgt = $signed(a) > $signed(b);
			ugt = a > b;
			case (k)
				KIND_EQ: lane_hit = eq;
				KIND_NE: lane_hit = !eq;
				KIND_GT: lane_hit = sgt;
				KIND_GE: lane_hit = sgt | eq;
				KIND_LT: lane_hit = !(sgt | eq);
				KIND_LE: lane_hit = !sgt;
				KIND_GTU: lane_hit = ugt;
				KIND_GEU: lane_hit = ugt | eq;
				KIND_LTU: lane_hit = !(ugt | eq);
				KIND_LEU: lane_hit = !ugt;
				default: lane_hit = 1'b0;
			endcase
		end
	endfunction

	always_comb begin
		logic sgn;
		sgn = is_signed_kind(kind);
		mask = DATA_RST;
		if (byte_lanes) begin
			for (int i = 0; i < 4; i++) begin
				mask[i*8 +: 8] = {8{lane_hit(widen(lhs[i*8 +: 8], sgn),
					widen(rhs[i*8 +: 8], sgn), kind)}};
			end
		end else begin
			for (int i = 0; i < 2; i++) begin
				mask[i*16 +: 16] = {16{lane_hit(lhs[i*16 +: 16], rhs[i*16 +: 16], kind)}};
			end
		end
	end

endmodule

// ==== design/simd_compare_and_complex_alu.sv ====
// Decode and datapath for packed lane compares and complex halfword arithmetic
//
// What this block does
// - Compare needs custom opcode in 6:0 and bit 26 set; fields at fixed spots.
// - Function values 0 through 9 are the ten compare kinds; others are not compares.
// - Six sub-codes per kind; register forms need bit 25 clear, 110/111 use immediate.
// - Immediate low bit comes from bit 25, upper five bits from 24:20.
// - Complex operations use halfword lanes and register operands only.
// - Register holds real part in low halfword, imaginary part in high halfword.
// - Subtract-rotate: low=im1-im2, high=re2-re1, masked, shifted right 0 to 3.
// - Conjugate keeps real half and negates imaginary half.
// - Real multiply writes re*re minus im*im shifted 15 to 18 into low half only.
// - Imaginary multiply writes re*im plus im*re shifted 15 to 18 into high half only.
// - Full product takes two instructions; old destination is read as an operand.
// - No flags raised, no control or status state touched.
// - Complex results wrap to 16 bits, no saturation or overflow signalling.
// - Complex codes 0x0d subtract-rotate, 0x0b conjugate, 0x0a multiply with variant bits.
// - Each compare lane becomes all ones when true, all zeros when false.
// - Vector uses lane i of source two, scalar its lowest lane, immediate the immediate.
// - Kinds: eq, ne, signed gt ge lt le, then unsigned gt ge lt le.
`timescale 1ns/10ps
module simd_compare_and_complex_alu (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic issue_valid,
	input wire logic [31:0] issue_instr,
	input wire logic [31:0] src1_data,
	input wire logic [31:0] src2_data,
	input wire logic [31:0] dest_old_data,
	output logic wb_valid_r,
	output logic wb_hit_r,
	output logic [4:0] wb_dest_r,
	output logic [31:0] wb_data_r
);
	import simd_alu_pkg::*;

	// Scaled multiply result: arithmetic shift of the full sum, low 16 bits kept
	function automatic logic [15:0] scale_mul(input logic signed [32:0] sum, input logic [1:0] s);
		logic [5:0] amt;
		logic signed [32:0] sh;
		begin
			amt = MUL_BASE_SHIFT + {4'h0, s};
			sh = sum >>> amt;
			scale_mul = sh[15:0];
		end
	endfunction

	// Wrapped difference shifted logically, as the 16-bit mask implies
	function automatic logic [15:0] scale_diff(input logic [15:0] a, input logic [15:0] b,
		input logic [1:0] s);
		logic [15:0] d;
		begin
			d = a - b;
			scale_diff = d >> s;
		end
	endfunction

	logic [6:0] opc;
	logic [4:0] func;
	logic [2:0] sub;
	logic group_bit;
	logic imm_low;
	logic [5:0] lane_imm;
	logic byte_lanes;
	logic [1:0] form;
	logic cmp_hit;
	logic subrot_hit;
	logic conj_hit;
	logic mul_hit;
	logic imm_sign;
	logic [7:0] imm_b;
	logic [15:0] imm_h;
	logic [31:0] cmp_rhs;
	logic [31:0] cmp_mask;
	cmp_kind_t kind;
	logic signed [15:0] re1;
	logic signed [15:0] im1;
	logic signed [15:0] re2;
	logic signed [15:0] im2;
	logic signed [31:0] p_rr;
	logic signed [31:0] p_ii;
	logic signed [31:0] p_ri;
	logic signed [31:0] p_ir;
	logic signed [32:0] sum_re;
	logic signed [32:0] sum_im;
	logic [31:0] alu_out;
	logic wb_valid_nxt;
	logic wb_hit_nxt;
	logic [4:0] wb_dest_nxt;
	logic [31:0] wb_data_nxt;

	assign opc = issue_instr[OPC_MSB:OPC_LSB];
	assign func = issue_instr[FUNC_MSB:FUNC_LSB];
	assign sub = issue_instr[SUB_MSB:SUB_LSB];
	assign group_bit = issue_instr[GROUP_BIT];
	assign imm_low = issue_instr[IMM_LOW_BIT];
	assign lane_imm = {issue_instr[SRC2_MSB:SRC2_LSB], imm_low};
	assign byte_lanes = sub[0];
	assign form = sub[2:1];
	assign kind = cmp_kind_t'(func[3:0]);

	always_comb begin
		logic base;
		base = (opc == OPC_CUSTOM) && group_bit;
		// valid forms, register forms need bit 25 clear
		cmp_hit = base && (func <= FUNC_CMP_LAST) &&
			((form == FORM_IMM) || (!imm_low && (form == FORM_VECTOR || form == FORM_SCALAR)));
		// halfword register forms only, bit 25 clear
		subrot_hit = base && !imm_low && (func == FUNC_CPLX_SUBROT) && !sub[0];
		conj_hit = base && !imm_low && (func == FUNC_CPLX_CONJ) && (sub == 3'h0);
		mul_hit = base && !imm_low && (func == FUNC_CPLX_MUL);
	end

	// sign follows comparison kind; equality kinds sign-extend
	assign imm_sign = (kind <= KIND_LE) & lane_imm[5];
	assign imm_b = {{2{imm_sign}}, lane_imm};
	assign imm_h = {{10{imm_sign}}, lane_imm};

	always_comb begin
		cmp_rhs = src2_data;
		if (form == FORM_SCALAR) begin
			cmp_rhs = byte_lanes ? {4{src2_data[7:0]}} : {2{src2_data[15:0]}};
		end else if (form == FORM_IMM) begin
			cmp_rhs = byte_lanes ? {4{imm_b}} : {2{imm_h}};
		end
	end

	lane_compare_unit cmp_u (
		.lhs(src1_data),
		.rhs(cmp_rhs),
		.kind(kind),
		.byte_lanes(byte_lanes),
		.mask(cmp_mask)
	);

	assign re1 = src1_data[15:0];
	assign im1 = src1_data[31:16];
	assign re2 = src2_data[15:0];
	assign im2 = src2_data[31:16];
	assign p_rr = re1 * re2;
	assign p_ii = im1 * im2;
	assign p_ri = re1 * im2;
	assign p_ir = im1 * re2;
	assign sum_re = 33'(p_rr) - 33'(p_ii);
	assign sum_im = 33'(p_ri) + 33'(p_ir);

	// Result select; only the 32-bit result leaves, so nothing else can be flagged
	always_comb begin
		alu_out = DATA_RST;
		if (cmp_hit) begin
			alu_out = cmp_mask;
		end else if (subrot_hit) begin
			// subtract and rotate by minus j
			alu_out = {scale_diff(re2, re1, sub[2:1]), scale_diff(im1, im2, sub[2:1])};
		end else if (conj_hit) begin
			alu_out = {16'h0000 - src1_data[31:16], src1_data[15:0]};
		end else if (mul_hit) begin
			if (sub[0]) begin
				alu_out = {scale_mul(sum_im, sub[2:1]), dest_old_data[15:0]};
			end else begin
				alu_out = {dest_old_data[31:16], scale_mul(sum_re, sub[2:1])};
			end
		end
	end

	// outputs carry only valid, hit, result and destination, no flag state
	always_comb begin
		wb_valid_nxt = issue_valid;
		wb_hit_nxt = issue_valid && (cmp_hit || subrot_hit || conj_hit || mul_hit);
		wb_dest_nxt = issue_instr[DEST_MSB:DEST_LSB];
		wb_data_nxt = alu_out;
		if (sys_rst) begin
			wb_valid_nxt = 1'b0;
			wb_hit_nxt = 1'b0;
			wb_dest_nxt = DEST_RST;
			wb_data_nxt = DATA_RST;
		end
	end

	always_ff @(posedge clk) begin
		wb_valid_r <= wb_valid_nxt;
		wb_hit_r <= wb_hit_nxt;
		wb_dest_r <= wb_dest_nxt;
		wb_data_r <= wb_data_nxt;
	end

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence issue_cmp_s;
		issue_valid && opc == OPC_CUSTOM && group_bit && func <= FUNC_CMP_LAST
			&& sub == 3'h1 && !imm_low;
	endsequence

	sequence issue_conj_s;
		issue_valid && opc == OPC_CUSTOM && group_bit && func == FUNC_CPLX_CONJ
			&& sub == 3'h0 && !imm_low;
	endsequence

	sequence issue_mul_s(logic imag);
		issue_valid && opc == OPC_CUSTOM && group_bit && func == FUNC_CPLX_MUL
			&& !imm_low && sub[0] == imag;
	endsequence

	sequence issue_imm_s;
		issue_valid && cmp_hit && form == FORM_IMM;
	endsequence

	compare_decode_a: assert property (issue_cmp_s |=> wb_hit_r && wb_valid_r)
		else $error("byte vector compare not recognised");

	dest_copy_a: assert property (issue_valid
		|=> wb_dest_r == $past(issue_instr[DEST_MSB:DEST_LSB]))
		else $error("destination index not carried");

	func_range_a: assert property (issue_valid && func > FUNC_CMP_LAST
		&& func != FUNC_CPLX_MUL && func != FUNC_CPLX_CONJ && func != FUNC_CPLX_SUBROT
		|=> !wb_hit_r)
		else $error("unknown function accepted");

	refuse_zero_a: assert property (issue_valid
		&& !(cmp_hit || subrot_hit || conj_hit || mul_hit)
		|=> wb_valid_r && !wb_hit_r && wb_data_r == DATA_RST)
		else $error("foreign instruction left a result");

	reg_form_bit_a: assert property (issue_valid && func <= FUNC_CMP_LAST && imm_low
		&& form != FORM_IMM |=> !wb_hit_r)
		else $error("register compare with bit 25 set accepted");

	complex_form_a: assert property (issue_valid && func == FUNC_CPLX_SUBROT && sub[0]
		|=> !wb_hit_r)
		else $error("byte-lane complex form accepted");

	conj_decode_a: assert property (issue_conj_s |=> wb_hit_r && wb_valid_r)
		else $error("conjugate not recognised");

	subrot_decode_a: assert property (issue_valid && opc == OPC_CUSTOM && group_bit
		&& func == FUNC_CPLX_SUBROT && !sub[0] && !imm_low |=> wb_hit_r)
		else $error("subtract rotate not recognised");

	lane_mask_a: assert property (issue_cmp_s |=> (wb_data_r[7:0] == 8'h00 ||
		wb_data_r[7:0] == 8'hff) && (wb_data_r[31:24] == 8'h00 || wb_data_r[31:24] == 8'hff))
		else $error("compare lane not uniform");

	imm_equal_a: assert property (issue_valid && cmp_hit && form == FORM_IMM && byte_lanes
		&& kind == KIND_EQ && src1_data[7:0] == {{2{lane_imm[5]}}, lane_imm}
		|=> wb_data_r[7:0] == 8'hff)
		else $error("immediate equality lane missed");

	imm_zero_ext_a: assert property (issue_imm_s ##0 (!byte_lanes && kind == KIND_GTU
		&& src1_data[31:16] > {10'h000, lane_imm}) |=> wb_data_r[31:16] == 16'hffff)
		else $error("unsigned immediate not zero-extended");

	scalar_lane_a: assert property (issue_valid && cmp_hit && form == FORM_SCALAR
		&& byte_lanes && kind == KIND_EQ && src1_data[15:8] != src2_data[7:0]
		|=> wb_data_r[15:8] == 8'h00)
		else $error("scalar compare used wrong lane");

	unsigned_gt_a: assert property (issue_valid && cmp_hit && form == FORM_VECTOR
		&& !byte_lanes && kind == KIND_GTU && src1_data[31:16] > src2_data[31:16]
		|=> wb_data_r[31:16] == 16'hffff)
		else $error("unsigned greater lane wrong");

	conj_keep_a: assert property (issue_conj_s
		|=> wb_data_r[15:0] == $past(src1_data[15:0])
		&& wb_data_r[31:16] == 16'h0000 - $past(src1_data[31:16]))
		else $error("conjugate result wrong");

	mul_real_a: assert property (issue_mul_s(1'b0)
		|=> wb_hit_r && wb_data_r[31:16] == $past(dest_old_data[31:16]))
		else $error("real multiply disturbed high half");

	mul_imag_a: assert property (issue_mul_s(1'b1)
		|=> wb_hit_r && wb_data_r[15:0] == $past(dest_old_data[15:0]))
		else $error("imaginary multiply disturbed low half");

	subrot_plain_a: assert property (issue_valid && subrot_hit && sub == 3'h0
		|=> wb_data_r[15:0] == 16'($past(src1_data[31:16]) - $past(src2_data[31:16])))
		else $error("subtract rotate low half wrong");

	subrot_high_a: assert property (issue_valid && subrot_hit && sub == 3'h0
		|=> wb_data_r[31:16] == 16'($past(src2_data[15:0]) - $past(src1_data[15:0])))
		else $error("subtract rotate high half wrong");

	idle_quiet_a: assert property (!issue_valid |=> !wb_valid_r && !wb_hit_r)
		else $error("result without an issue");

endmodule

// ==== verif/regfile_model.sv ====
// Register file and decode-side model feeding the unit and taking its writeback
`timescale 1ns/10ps
module regfile_model (
	input wire logic clk,
	input wire logic issue_valid,
	input wire logic [31:0] issue_instr,
	input wire logic wb_valid_r,
	input wire logic wb_hit_r,
	input wire logic [4:0] wb_dest_r,
	input wire logic [31:0] wb_data_r,
	output logic [31:0] src1_data,
	output logic [31:0] src2_data,
	output logic [31:0] dest_old_data
);
	logic [31:0] regs [32];

	initial begin
		for (int i = 0; i < 32; i++) begin
			regs[i] = 32'h0;
		end
	end

	// Inverted data outside an issue, so a stale read is never taken for a fresh one
	assign src1_data = issue_valid ? regs[issue_instr[19:15]] : ~regs[issue_instr[19:15]];
	assign src2_data = issue_valid ? regs[issue_instr[24:20]] : ~regs[issue_instr[24:20]];
	assign dest_old_data = issue_valid ? regs[issue_instr[11:7]] : ~regs[issue_instr[11:7]];

	// No forwarding here: a dependent issue must leave one idle cycle
	always @(posedge clk) begin
		if (wb_valid_r && wb_hit_r && wb_dest_r != 5'h00) begin
			regs[wb_dest_r] <= wb_data_r;
		end
	end

	task load(input logic [4:0] idx, input logic [31:0] val);
		if (idx != 5'h00) begin
			regs[idx] = val;
		end
	endtask
endmodule

// ==== verif/tb_simd_compare_and_complex_alu.sv ====
// Self-checking bench for the lane compare and complex halfword unit
`timescale 1ns/10ps
module tb_simd_compare_and_complex_alu;
	import simd_alu_pkg::*;
	localparam logic [31:0] R1 = 32'h80ff_0005;
	localparam logic [31:0] R2 = 32'h7fff_0005;
	localparam logic [31:0] R3 = 32'hff80_7f01;
	localparam logic [31:0] R4 = 32'h8000_8000;
	localparam logic [31:0] R5 = 32'h7fff_8000;
	localparam logic [31:0] R6 = 32'h1234_5678;
	logic clk = 1'h0;
	logic sys_rst = 1'h1;
	logic issue_valid = 1'h0;
	logic [31:0] issue_instr = 32'h0;
	logic [31:0] src1_data, src2_data, dest_old_data, wb_data_r;
	logic wb_valid_r, wb_hit_r;
	logic [4:0] wb_dest_r;
	int miscompares = 0;
	int n_checks = 0;

	always #2.5 clk = ~clk;

	simd_compare_and_complex_alu dut_u (.clk(clk), .sys_rst(sys_rst), .issue_valid(issue_valid),
		.issue_instr(issue_instr), .src1_data(src1_data), .src2_data(src2_data),
		.dest_old_data(dest_old_data), .wb_valid_r(wb_valid_r), .wb_hit_r(wb_hit_r),
		.wb_dest_r(wb_dest_r), .wb_data_r(wb_data_r));

	regfile_model pm_u (.clk(clk), .issue_valid(issue_valid), .issue_instr(issue_instr),
		.wb_valid_r(wb_valid_r), .wb_hit_r(wb_hit_r), .wb_dest_r(wb_dest_r),
		.wb_data_r(wb_data_r), .src1_data(src1_data), .src2_data(src2_data),
		.dest_old_data(dest_old_data));

	task automatic end_of_test();
		if (miscompares == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	function automatic logic [31:0] mk(logic [4:0] f5, logic b25, logic [4:0] rs2,
		logic [4:0] rs1, logic [2:0] f3, logic [4:0] rd);
		return {f5, 1'h1, b25, rs2, rs1, f3, rd, OPC_CUSTOM};
	endfunction

	task automatic run(logic [31:0] ins, logic hit, logic [31:0] exp);
		@(negedge clk);
		chk("idle_valid", 32'h0, {31'h0, wb_valid_r});
		issue_valid = 1'h1;
		issue_instr = ins;
		@(negedge clk);
		issue_valid = 1'h0;
		chk("valid", 32'h1, {31'h0, wb_valid_r});
		chk("hit", {31'h0, hit}, {31'h0, wb_hit_r});
		chk("dest", {27'h0, ins[11:7]}, {27'h0, wb_dest_r});
		chk("data", exp, wb_data_r);
	endtask

	task automatic ld(logic [4:0] idx, logic [31:0] val);
		@(negedge clk);
		pm_u.load(idx, val);
	endtask

	function automatic logic [31:0] cmp_exp(int k, logic [31:0] a, logic [31:0] b,
		logic [2:0] f3, logic [5:0] imm);
		int w, m, xu, yu, xs, ys;
		logic r;
		logic [31:0] res;
		w = f3[0] ? 8 : 16;
		m = (1 << w) - 1;
		res = 32'h0;
		for (int i = 0; i < 32 / w; i++) begin
			xu = (a >> (i * w)) & m;
			yu = (f3[2:1] == FORM_VECTOR) ? (b >> (i * w)) & m : b & m;
			if (f3[2:1] == FORM_IMM) begin
				yu = (k >= 6) ? imm : {{26{imm[5]}}, imm} & m;
			end
			xs = (xu >= (1 << (w - 1))) ? xu - (1 << w) : xu;
			ys = (yu >= (1 << (w - 1))) ? yu - (1 << w) : yu;
			case (k)
				0: r = xu == yu;
				1: r = xu != yu;
				2: r = xs > ys;
				3: r = xs >= ys;
				4: r = xs < ys;
				5: r = xs <= ys;
				6: r = xu > yu;
				7: r = xu >= yu;
				8: r = xu < yu;
				default: r = xu <= yu;
			endcase
			if (r) begin
				res = res | (m << (i * w));
			end
		end
		return res;
	endfunction

	function automatic logic [31:0] subrot(logic [31:0] a, logic [31:0] b, int n);
		logic [15:0] lo, hi;
		lo = a[31:16] - b[31:16];
		hi = b[15:0] - a[15:0];
		return {hi >> n, lo >> n};
	endfunction

	function automatic logic [15:0] cmul(logic [31:0] a, logic [31:0] b, logic im, int n);
		longint s;
		if (im) begin
			s = $signed(a[15:0]) * $signed(b[31:16]) + $signed(a[31:16]) * $signed(b[15:0]);
		end else begin
			s = $signed(a[15:0]) * $signed(b[15:0]) - $signed(a[31:16]) * $signed(b[31:16]);
		end
		s = s >>> (15 + n);
		return s[15:0];
	endfunction

	task automatic t_reset();
		@(negedge clk);
		sys_rst = 1'h1;
		issue_valid = 1'h1;
		issue_instr = mk(5'h00, 1'h0, 5'h01, 5'h01, 3'h0, 5'h03);
		@(negedge clk);
		sys_rst = 1'h0;
		issue_valid = 1'h0;
		chk("rst_valid", 32'h0, {31'h0, wb_valid_r});
		chk("rst_data", 32'h0, wb_data_r);
	endtask

	task automatic t_compare();
		logic [2:0] f3s [6];
		logic [5:0] imm;
		logic [31:0] ins;
		f3s = '{3'h0, 3'h4, 3'h6, 3'h1, 3'h5, 3'h7};
		for (int k = 0; k < 10; k++) begin
			for (int j = 0; j < 12; j++) begin
				imm = j[0] ? 6'h05 : 6'h3f;
				ins = mk(k[4:0], 1'h0, j[0] ? 5'h03 : 5'h02, 5'h01, f3s[j / 2], 5'h0a + k[4:0]);
				if (f3s[j / 2][2:1] == FORM_IMM) begin
					ins = mk(k[4:0], imm[0], imm[5:1], 5'h01, f3s[j / 2], 5'h0a + k[4:0]);
				end
				run(ins, 1'h1, cmp_exp(k, R1, j[0] ? R3 : R2, f3s[j / 2], imm));
			end
		end
	endtask

	task automatic t_complex();
		logic [31:0] ins;
		logic [2:0] f3;
		for (int n = 0; n < 4; n++) begin
			f3 = {n[1:0], 1'h0};
			ins = mk(FUNC_CPLX_SUBROT, 1'h0, 5'h03, 5'h04, f3, 5'h08);
			run(ins, 1'h1, subrot(R4, R3, n));
			ld(5'h06, R6);
			ins = mk(FUNC_CPLX_MUL, 1'h0, 5'h05, 5'h04, f3, 5'h06);
			run(ins, 1'h1, {R6[31:16], cmul(R4, R5, 1'h0, n)});
			ld(5'h06, R6);
			run(ins | 32'h1000, 1'h1, {cmul(R4, R5, 1'h1, n), R6[15:0]});
		end
		run(mk(FUNC_CPLX_CONJ, 1'h0, 5'h00, 5'h05, 3'h0, 5'h08), 1'h1, 32'h8001_8000);
		run(mk(FUNC_CPLX_CONJ, 1'h0, 5'h00, 5'h04, 3'h0, 5'h08), 1'h1, R4);
		ld(5'h07, 32'hdead_beef);
		ins = mk(FUNC_CPLX_MUL, 1'h0, 5'h05, 5'h04, 3'h0, 5'h07);
		run(ins, 1'h1, {16'hdead, cmul(R4, R5, 1'h0, 0)});
		run(ins | 32'h1000, 1'h1, {cmul(R4, R5, 1'h1, 0), cmul(R4, R5, 1'h0, 0)});
	endtask

	task automatic t_refuse();
		logic [31:0] bad [9];
		bad = '{mk(5'h00, 1'h0, 5'h02, 5'h01, 3'h2, 5'h03),
			mk(5'h00, 1'h1, 5'h02, 5'h01, 3'h0, 5'h03),
			mk(5'h0c, 1'h0, 5'h02, 5'h01, 3'h0, 5'h04),
			mk(5'h0d, 1'h0, 5'h02, 5'h01, 3'h1, 5'h05),
			mk(5'h0b, 1'h0, 5'h00, 5'h01, 3'h4, 5'h06),
			mk(5'h0a, 1'h1, 5'h02, 5'h01, 3'h0, 5'h07),
			mk(5'h1f, 1'h0, 5'h02, 5'h01, 3'h0, 5'h08),
			mk(5'h00, 1'h0, 5'h02, 5'h01, 3'h0, 5'h09) & ~32'h0400_0000,
			mk(5'h00, 1'h0, 5'h02, 5'h01, 3'h0, 5'h0a) ^ 32'h1};
		for (int i = 0; i < 9; i++) begin
			run(bad[i], 1'h0, 32'h0);
		end
	endtask

	initial begin
		repeat (8) @(negedge clk);
		sys_rst = 1'h0;
		pm_u.load(5'h01, R1);
		pm_u.load(5'h02, R2);
		pm_u.load(5'h03, R3);
		pm_u.load(5'h04, R4);
		pm_u.load(5'h05, R5);
		t_reset();
		t_compare();
		t_complex();
		t_refuse();
		end_of_test();
	end

	// Whole run needs under 2000 cycles; this leaves ample margin
	initial begin
		#50000;
		miscompares++;
		end_of_test();
	end
endmodule
